// file: design/modem_pin_regs.vh
`ifndef MODEM_PIN_REGS_VH
`define MODEM_PIN_REGS_VH

// Multi-function select field, alternate function bits 2:1
`define MF_SEL_LSB       1
`define MF_SEL_MSB       2
`define MF_SEL_GPO2      2'h0
`define MF_SEL_BAUD      2'h1
`define MF_SEL_RXRDY     2'h2

// Modem control bit positions
`define MCR_DTR_BIT      0
`define MCR_OUT2_BIT     3
`define MCR_RESET_VAL    8'h00

// Enhanced feature / interrupt enable bits for auto CTS
`define EFR_AUTO_CTS_BIT 7
`define IER_CTS_BIT      7

// Reset pulse width and baud clock ratio
`define RESET_MIN_NS     40
`define CLK_PERIOD_PS    5000
`define RESET_MIN_CYC    ((`RESET_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BAUD_OVERSAMPLE  16

`endif

// file: design/input_sync.v
`timescale 1ns/1ps

// ****************************************
// Two-stage level synchroniser, one per bit
// ****************************************
module input_sync #(
    parameter WIDTH     = 4,
    parameter RESET_VAL = 4'hF
) (
    // Clock and reset
    input  wire             ref_clk_in,
    input  wire             resetn_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // First stage is read only by the second
            always @(posedge ref_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    stage1_reg[i] <= RESET_VAL[i];
                    stage2_reg[i] <= RESET_VAL[i];
                end else begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2_reg;

endmodule // input_sync

// file: design/uart_modem_pins.v
`timescale 1ns/1ps
`include "modem_pin_regs.vh"

module uart_modem_pins (
    // Clock and reset
    input  wire       ref_clk_in,
    input  wire       resetn_in,
    // Configuration from register file
    input  wire [7:0] alternate_function_in,
    input  wire [7:0] modem_control_wdata_in,
    input  wire       modem_control_we_in,
    input  wire [7:0] enhanced_feature_in,
    input  wire [7:0] interrupt_enable_in,
    // Internal sources
    input  wire       baud16_clk_in,
    input  wire       rx_ready_n_in,
    input  wire       tx_serial_in,
    input  wire       rx_serial_in,
    // Modem pins
    input  wire       clear_to_send_in_n,
    input  wire       set_ready_in_n,
    input  wire       carrier_detect_in_n,
    input  wire       ring_indicator_in_n,
    output wire       terminal_ready_out_n,
    output wire       multi_function_out_n,
    output wire       tx_pin_out,
    // Status to core
    output wire [7:0] modem_control_out,
    output wire [3:0] modem_status_out,
    output wire       tx_allowed_out,
    output wire       rx_data_out
);

    // ****************************************
    // Modem input synchronisers
    // ****************************************
    wire [3:0] pins_sync;

    // Inputs idle high, so reset to inactive
    input_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'hF)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .async_in   ({ring_indicator_in_n, carrier_detect_in_n,
                      set_ready_in_n, clear_to_send_in_n}),
        .sync_out   (pins_sync)
    );

    // ****************************************
    // Modem control register
    // ****************************************
    reg [7:0] modem_control_reg;

    // Cleared on reset, bit 3 included
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            modem_control_reg <= `MCR_RESET_VAL;
        end else if (modem_control_we_in) begin
            modem_control_reg <= modem_control_wdata_in;
        end
    end

    // ****************************************
    // Select field decode
    // ****************************************
    // Compare the select field with one function code
    function sel_is;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_is = (sel == code);
        end
    endfunction

    wire [1:0] mf_sel;
    wire       use_out2;
    wire       use_baud;
    wire       use_rxrdy;

    // At most one of these can be high; code 3 leaves all low
    assign mf_sel    = alternate_function_in[`MF_SEL_MSB:`MF_SEL_LSB];
    assign use_out2  = sel_is(mf_sel, `MF_SEL_GPO2);
    assign use_baud  = sel_is(mf_sel, `MF_SEL_BAUD);
    assign use_rxrdy = sel_is(mf_sel, `MF_SEL_RXRDY);

    // ****************************************
    // Multi-function source mux
    // ****************************************
    reg mf_next;
    reg mf_reg;

    // One source only; reserved code parks the pin inactive high
    always @* begin
        mf_next = 1'b1;
        if (use_out2) begin
            mf_next = ~modem_control_reg[`MCR_OUT2_BIT];
        end else if (use_baud) begin
            mf_next = baud16_clk_in;
        end else if (use_rxrdy) begin
            mf_next = rx_ready_n_in;
        end else begin
            mf_next = 1'b1;
        end
    end

    // ****************************************
    // Multi-function pin register
    // ****************************************
    // Registered so the pin never glitches while the select moves;
    // the baud clock lags one cycle and must stay below half ref_clk
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mf_reg <= 1'b1;
        end else begin
            mf_reg <= mf_next;
        end
    end

    // ****************************************
    // Terminal-ready pin
    // ****************************************
    reg  dtr_reg;
    wire dtr_next;

    // Active low copy of the software bit
    assign dtr_next = ~modem_control_reg[`MCR_DTR_BIT];

    // Inactive high from reset until software asserts it
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dtr_reg <= 1'b1;
        end else begin
            dtr_reg <= dtr_next;
        end
    end

    // ****************************************
    // Clear-to-send transmit gate
    // ****************************************
    reg  cts_ok_reg;
    wire auto_cts_en;
    wire cts_asserted;
    wire cts_ok_next;

    // Auto CTS needs both enables; otherwise CTS is status only
    assign auto_cts_en  = enhanced_feature_in[`EFR_AUTO_CTS_BIT] &
                          interrupt_enable_in[`IER_CTS_BIT];
    assign cts_asserted = ~pins_sync[0];
    assign cts_ok_next  = ~auto_cts_en | cts_asserted;

    // Only the synchronised CTS bit reaches the gate
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cts_ok_reg <= 1'b1;
        end else begin
            cts_ok_reg <= cts_ok_next;
        end
    end

    // ****************************************
    // Serial transmit pin
    // ****************************************
    reg tx_reg;

    // Held at idle high for the whole reset period
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_reg <= 1'b1;
        end else begin
            tx_reg <= tx_serial_in;
        end
    end

    // ****************************************
    // Serial receive path
    // ****************************************
    reg rx_reg;

    // Pin activity is masked to idle while reset is held
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_reg <= 1'b1;
        end else begin
            rx_reg <= rx_serial_in;
        end
    end

    // ****************************************
    // Modem status register
    // ****************************************
    reg [3:0] status_reg;

    // DSR, CD and RI feed status only, nothing else
    // Third stage adds a cycle but keeps the output a flop
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_reg <= 4'hF;
        end else begin
            status_reg <= pins_sync;
        end
    end

    // ****************************************
    // Output wiring
    // ****************************************
    // Every output is a flop; no logic after the registers
    assign multi_function_out_n = mf_reg;
    assign terminal_ready_out_n = dtr_reg;
    assign tx_allowed_out       = cts_ok_reg;
    assign tx_pin_out           = tx_reg;
    assign rx_data_out          = rx_reg;
    assign modem_status_out     = status_reg;
    assign modem_control_out    = modem_control_reg;

endmodule // uart_modem_pins

// file: dv/uart_modem_pins_chk.sv
`timescale 1ns/1ps
// ************
// Pin checker
// ************
module uart_modem_pins_chk (
    input wire       ref_clk_in, resetn_in, modem_control_we_in, baud16_clk_in,
    input wire       rx_ready_n_in, tx_serial_in, rx_serial_in, terminal_ready_out_n,
    input wire       multi_function_out_n, tx_pin_out, rx_data_out, clear_to_send_in_n,
    input wire       set_ready_in_n, carrier_detect_in_n, ring_indicator_in_n,
    input wire [7:0] alternate_function_in, modem_control_wdata_in, modem_control_out,
    input wire [3:0] modem_status_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // Short aliases keep each property but p_ser on one line
    wire       r  = resetn_in;
    wire       mf = multi_function_out_n;
    wire [7:0] mc = modem_control_out;
    wire [1:0] sel = alternate_function_in[2:1];
    wire [3:0] ms = {ring_indicator_in_n, carrier_detect_in_n, set_ready_in_n, clear_to_send_in_n};
    property p_out2; $past(r) && $past(sel) == 2'h0 |-> mf == !$past(mc[3]); endproperty
    a_out2: assert property (p_out2) else $error("mf not output two");
    property p_baud; $past(r) && $past(sel) == 2'h1 |-> mf == $past(baud16_clk_in); endproperty
    a_baud: assert property (p_baud) else $error("mf not baud clock");
    property p_rdy; $past(r) && $past(sel) == 2'h2 |-> mf == $past(rx_ready_n_in); endproperty
    a_rdy: assert property (p_rdy) else $error("mf not rx ready");
    property p_dtr; terminal_ready_out_n == !$past(mc[0]); endproperty
    a_dtr: assert property (p_dtr) else $error("dtr wrong");
    property p_wr; modem_control_we_in |=> mc == $past(modem_control_wdata_in); endproperty
    a_wr: assert property (p_wr) else $error("mcr write lost");
    // Reset cannot disable its own check
    property p_rst; disable iff (1'b0) !r |-> tx_pin_out && mc == 8'h00 && mf; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_ser; $past(r) |-> {tx_pin_out, rx_data_out} == $past({tx_serial_in, rx_serial_in});
    endproperty
    a_ser: assert property (p_ser) else $error("serial path wrong");
    property p_sync; $past(r, 4) |-> modem_status_out == $past(ms, 3); endproperty
    a_sync: assert property (p_sync) else $error("status latency wrong");
endmodule // uart_modem_pins_chk

bind uart_modem_pins uart_modem_pins_chk u_chk (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .modem_control_we_in(modem_control_we_in),
    .baud16_clk_in(baud16_clk_in), .rx_ready_n_in(rx_ready_n_in), .tx_serial_in(tx_serial_in),
    .rx_serial_in(rx_serial_in), .terminal_ready_out_n(terminal_ready_out_n),
    .multi_function_out_n(multi_function_out_n), .tx_pin_out(tx_pin_out),
    .rx_data_out(rx_data_out), .clear_to_send_in_n(clear_to_send_in_n),
    .set_ready_in_n(set_ready_in_n), .carrier_detect_in_n(carrier_detect_in_n),
    .ring_indicator_in_n(ring_indicator_in_n), .alternate_function_in(alternate_function_in),
    .modem_control_wdata_in(modem_control_wdata_in), .modem_control_out(modem_control_out),
    .modem_status_out(modem_status_out));

// file: dv/modem_far.sv
`timescale 1ns/1ps
// **************
// Far-side modem
// **************
module modem_far #(
    parameter DLY = 1
) (
    input  wire [3:0] req_in,
    output wire       clear_to_send_in_n, set_ready_in_n, carrier_detect_in_n, ring_indicator_in_n
);
    // Lines idle high; delay stands for a slow modem
    assign #DLY {ring_indicator_in_n, carrier_detect_in_n, set_ready_in_n,
                 clear_to_send_in_n} = ~req_in;
endmodule // modem_far

// file: dv/tb_uart_modem_pins.sv
`timescale 1ns/1ps
// ***********
// Pin bench
// ***********
module tb_uart_modem_pins;
    reg        ref_clk_in = 1'b0, resetn_in = 1'b1, modem_control_we_in = 1'b0;
    reg        baud16_clk_in = 1'b1, rx_ready_n_in = 1'b1, tx_serial_in = 1'b1, rx_serial_in = 1'b1;
    reg  [7:0] alternate_function_in = 8'h00, modem_control_wdata_in = 8'h00;
    reg  [7:0] enhanced_feature_in = 8'h80, interrupt_enable_in = 8'h80;
    reg  [3:0] req_in = 4'h0;
    wire       clear_to_send_in_n, set_ready_in_n, carrier_detect_in_n, ring_indicator_in_n;
    wire       terminal_ready_out_n, multi_function_out_n, tx_pin_out, tx_allowed_out, rx_data_out;
    wire [7:0] modem_control_out;
    wire [3:0] modem_status_out;
    integer    errors = 0, num_checks = 0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    modem_far u_far (.req_in(req_in), .clear_to_send_in_n(clear_to_send_in_n),
        .set_ready_in_n(set_ready_in_n), .carrier_detect_in_n(carrier_detect_in_n),
        .ring_indicator_in_n(ring_indicator_in_n));
    uart_modem_pins u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .alternate_function_in(alternate_function_in),
        .modem_control_wdata_in(modem_control_wdata_in),
        .modem_control_we_in(modem_control_we_in), .enhanced_feature_in(enhanced_feature_in),
        .interrupt_enable_in(interrupt_enable_in), .baud16_clk_in(baud16_clk_in),
        .rx_ready_n_in(rx_ready_n_in), .tx_serial_in(tx_serial_in),
        .rx_serial_in(rx_serial_in), .clear_to_send_in_n(clear_to_send_in_n),
        .set_ready_in_n(set_ready_in_n), .carrier_detect_in_n(carrier_detect_in_n),
        .ring_indicator_in_n(ring_indicator_in_n), .terminal_ready_out_n(terminal_ready_out_n),
        .multi_function_out_n(multi_function_out_n), .tx_pin_out(tx_pin_out),
        .modem_control_out(modem_control_out), .modem_status_out(modem_status_out),
        .tx_allowed_out(tx_allowed_out), .rx_data_out(rx_data_out));
    // Step 1 ns past the edge so inputs never race it
    task cyc(input integer n); begin repeat (n) @(posedge ref_clk_in); #1; end endtask
    task chk(input [23:0] nm, input [7:0] e, input [7:0] g); begin
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    end endtask
    task wr(input [7:0] d); begin
        modem_control_wdata_in = d;
        modem_control_we_in = 1'b1;
        cyc(1);
        modem_control_we_in = 1'b0;
    end endtask
    task t_out2; begin
        wr(8'h08); cyc(1);
        chk("mf", 8'h00, multi_function_out_n);
        chk("dtr", 8'h01, terminal_ready_out_n);
        wr(8'h01); cyc(1);
        chk("mf", 8'h01, multi_function_out_n);
        chk("dtr", 8'h00, terminal_ready_out_n);
        $display("t_out2 done");
    end endtask
    task t_sel; begin
        alternate_function_in = 8'h02; baud16_clk_in = 1'b0; cyc(2);
        chk("bd0", 8'h00, multi_function_out_n);
        baud16_clk_in = 1'b1; cyc(1);
        chk("bd1", 8'h01, multi_function_out_n);
        alternate_function_in = 8'h04; rx_ready_n_in = 1'b0; cyc(2);
        chk("rdy", 8'h00, multi_function_out_n);
        alternate_function_in = 8'h06; cyc(2);
        chk("prk", 8'h01, multi_function_out_n);
        alternate_function_in = 8'h00; cyc(2);
        chk("op2", 8'h01, multi_function_out_n);
        $display("t_sel done");
    end endtask
    task t_cts; begin
        req_in = 4'hE; cyc(5);
        chk("st", 8'h01, modem_status_out);
        chk("ok", 8'h00, tx_allowed_out);
        req_in = 4'h1; cyc(2);
        chk("st", 8'h01, modem_status_out);
        cyc(1);
        chk("st", 8'h0E, modem_status_out);
        cyc(2);
        chk("ok", 8'h01, tx_allowed_out);
        enhanced_feature_in = 8'h00; req_in = 4'hE; cyc(5);
        chk("st", 8'h01, modem_status_out);
        chk("ok", 8'h01, tx_allowed_out);
        $display("t_cts done");
    end endtask
    task t_reset; begin
        wr(8'h09); cyc(2);
        resetn_in = 1'b0; rx_serial_in = 1'b0; tx_serial_in = 1'b0; cyc(8);
        chk("mcr", 8'h00, modem_control_out);
        chk("pin", 8'h0F, {tx_pin_out, rx_data_out, multi_function_out_n, terminal_ready_out_n});
        resetn_in = 1'b1; cyc(2);
        chk("rel", 8'h01, {tx_pin_out, rx_data_out, multi_function_out_n});
        $display("t_reset done");
    end endtask
    task wrap_up; begin
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end endtask
    // Whole run is under 100 cycles
    initial begin
        #5000;
        errors = errors + 1;
        wrap_up;
    end
    initial begin
        #1; resetn_in = 1'b0;
        cyc(2); resetn_in = 1'b1; cyc(1);
        t_out2; t_sel; t_cts; t_reset;
        wrap_up;
    end
endmodule // tb_uart_modem_pins
